// ---- rtl/dspmm_pkg.sv ----
// Types for the memory map and wait-state block
package dspmm_pkg;
    typedef enum logic [1:0] {
        DSPMM_IDLE = 2'b00,
        DSPMM_WAIT = 2'b01,
        DSPMM_RDY  = 2'b10
    } dspmm_state_t;
    typedef enum logic [2:0] {
        DSPMM_SEL_NONE  = 3'b000,
        DSPMM_SEL_DUAL_ACCESS_RAM = 3'b001,
        DSPMM_SEL_SINGLE_ACCESS_RAM = 3'b010,
        DSPMM_SEL_ROM   = 3'b011,
        DSPMM_SEL_EXT   = 3'b100
    } dspmm_sel_t;
    typedef enum logic [2:0] {
        DSPMM_PGOP_NONE  = 3'b000,
        DSPMM_PGOP_FAR   = 3'b001,
        DSPMM_PGOP_TABLE = 3'b010,
        DSPMM_PGOP_TRAP  = 3'b011,
        DSPMM_PGOP_OTHER = 3'b100
    } dspmm_pgop_t;
    typedef enum logic [1:0] {
        DSPMM_SP_PROG = 2'b00,
        DSPMM_SP_DATA = 2'b01,
        DSPMM_SP_IO   = 2'b10
    } dspmm_space_t;
endpackage

// ---- rtl/dspmm_regs.svh ----
// Register offsets, field positions, reset values and decode bounds for memory map
`ifndef DSPMM_REGS_SVH
`define DSPMM_REGS_SVH
`define DSPMM_PAGE_ADDR      16'h001E
`define DSPMM_WS_ADDR        16'h0028
`define DSPMM_WSCTL_ADDR     16'h002B
`define DSPMM_PAGE_RST       7'h00
`define DSPMM_WS_RST         16'h7FFF
`define DSPMM_WSCTL_RST      1'h0
`define DSPMM_VEC_RST        9'h1FF
`define DSPMM_XPA_BIT        15
`define DSPMM_IO_HI          14
`define DSPMM_IO_LO          12
`define DSPMM_DHI_HI         11
`define DSPMM_DHI_LO         9
`define DSPMM_DLO_HI         8
`define DSPMM_DLO_LO         6
`define DSPMM_PHI_HI         5
`define DSPMM_PHI_LO         3
`define DSPMM_PLO_HI         2
`define DSPMM_PLO_LO         0
`define DSPMM_DUAL_ACCESS_RAM_LO       16'h0080
`define DSPMM_DUAL_ACCESS_RAM_HI       16'h1FFF
`define DSPMM_SINGLE_ACCESS_RAM_LO       16'h2000
`define DSPMM_SINGLE_ACCESS_RAM_HI       16'h7FFF
`define DSPMM_PROGRAM_RAM_IN_DATA_ENABLE_LO        16'h8000
`define DSPMM_ROM_LO         16'hC000
`define DSPMM_PROT_LO        23'h001000
`define DSPMM_PROT_HI        23'h001FFF
`define DSPMM_COMMON_BIT     15
`define DSPMM_PROGRAM_RAM_IN_DATA_ENABLE_PAGE      7'h01
`define DSPMM_ZERO_PAGE      7'h00
`define DSPMM_VEC_SHIFT      7
`define DSPMM_SLOT_SHIFT     2
`define DSPMM_WS_ZERO        4'h0
`define DSPMM_WS_ONE         4'h1
`endif

// ---- rtl/dspmm_top.sv ----
// Memory decode, program paging, vector relocation and wait-state generation
//
// Contract
// RL1: Dual-access RAM: four 2K blocks, two ports.
// RL2: Dual-access RAM at data 0080h-1FFFh, overlay into program.
// RL3: Seven 8K single-access blocks, one access each.
// RL4: Data 2000h-7FFFh also program when overlay set.
// RL5: Program 18000h-1FFFFh also data when enabled.
// RL6: Protection blocks external fetches from on-chip memory.
// RL7: Protected host reads only 1000h-1FFFh; writes free.
// RL8: Program address outside on-chip bounds goes external.
// RL9: Data address outside on-chip RAM goes external.
// RL10: Vector slots span four words; PC loads slot.
// RL11: Vectors at FF80h; pointer relocates to 128-word page.
// RL12: Hardware reset sets vector pointer all ones.
// RL13: Program space 23 bits, 128 pages of 64K.
// RL14: Overlay maps offsets 0000-7FFF to common RAM; the code maps 0080-7FFF and sends 0000-007F external.
// RL15: ROM decodes only on page zero.
// RL16: Page register at 001Eh, read/write, resets zero.
// RL17: Far ops and table ops use 23-bit addresses.
// RL18: Other instructions and interrupts keep page.
// RL19: Up to fourteen wait states; longer via ready.
// RL20: All-zero wait fields gate the wait generator.
// RL21: Five 3-bit wait fields: program, data, I/O.
// RL22: Wait count equals field, doubled by multiplier.
// RL23: Reset loads 7FFFh, multiplier clear.
// RL24: I/O 14-12, data 11-9 and 8-6, bit 15 range.
// RL25: Multiplier at bit 0 of control at 2Bh.
// RL26: Slow external device holds ready low.
`timescale 1ns/1ns
`include "dspmm_regs.svh"
module dspmm_top (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 boot_memory_strap,
    input  wire logic                 rom_protect,
    input  wire logic                 ram_overlay_enable,
    input  wire logic                 program_ram_in_data_enable,
    input  wire logic                 mmr_we,
    input  wire logic [15:0]          mmr_addr,
    input  wire logic [15:0]          mmr_wdata,
    input  wire logic                 vec_we,
    input  wire logic [8:0]           vec_wdata,
    input  wire logic                 prog_req,
    input  wire logic [15:0]          prog_addr,
    input  wire logic                 prog_fetch_ext,
    input  wire dspmm_pkg::dspmm_pgop_t pg_op,
    input  wire logic [22:0]          pg_target,
    input  wire logic [4:0]           trap_num,
    input  wire logic                 data_req,
    input  wire logic [15:0]          data_addr,
    input  wire logic                 io_req,
    input  wire logic                 host_req,
    input  wire logic                 host_we,
    input  wire logic [22:0]          host_addr,
    input  wire logic                 ext_ready,
    output logic [15:0]               mmr_rdata,
    output logic [6:0]                program_page_select,
    output logic [8:0]                vector_page_pointer,
    output logic [15:0]               trap_pc,
    output logic [22:0]               prog_bus_addr,
    output dspmm_pkg::dspmm_sel_t     prog_sel,
    output logic [2:0]                prog_block,
    output dspmm_pkg::dspmm_sel_t     data_sel,
    output logic [2:0]                data_block,
    output logic                      host_grant,
    output logic                      ext_busy,
    output logic                      ext_done,
    output logic                      wait_clk_gate
);
    import dspmm_pkg::*;

    // Map overview, program side:
    //   overlay set: offsets 0080-1FFF dual-access RAM,
    //   2000-7FFF single-access blocks 0 to 2, every page.
    //   strap low: page 0 C000-FFFF is ROM.
    //   mapping bit set or not: page 1 8000-FFFF is blocks 3 to 6.
    //   anything else goes to the external bus.
    //
    // Map overview, data side:
    //   0080-1FFF dual-access RAM, four 2K blocks.
    //   2000-7FFF single-access blocks 0 to 2.
    //   8000-FFFF blocks 3 to 6 when mapping set,
    //   external otherwise.
    //   0000-007F register space, no select.
    //
    // Hazards:
    //   protected external fetches never see on-chip memory.
    //   protected host reads outside the open window are refused,
    //   host writes always pass.
    //   a busy sequencer drops new external requests,
    //   so callers wait for the done pulse.
    //
    // Timing:
    //   decode, read data and grant one cycle after request.
    //   done at least two cycles after ready is seen high,
    //   through the two-flop ready synchroniser.
    //

    typedef struct packed {
        logic [6:0]   page;
        logic [15:0]  ws;
        logic         dbl;
        logic [8:0]   vec;
        logic [15:0]  rdata;
        logic [15:0]  tpc;
        logic [22:0]  pbus;
        dspmm_sel_t   psel;
        logic [2:0]   pblk;
        dspmm_sel_t   dsel;
        logic [2:0]   dblk;
        logic         hgnt;
        dspmm_state_t st;
        logic [3:0]   cnt;
        logic         busy;
        logic         done;
        logic         gate;
        logic         rdy_s1;
        logic         rdy_s2;
    } dspmm_st_t;

    dspmm_st_t s_q, s_d;

    // State fields:
    //   page, ws, dbl, vec - programmable registers.
    //   rdata - registered read data.
    //   tpc - vector slot address of the last trap.
    //   pbus - full 23-bit program bus address.
    //   psel, pblk, dsel, dblk - registered selects.
    //   hgnt - registered host grant.
    //   st, cnt, busy, done - external sequencer.
    //   gate - wait counter clock enable flag.
    //   rdy_s1, rdy_s2 - ready synchroniser.
    //

    // Decode scratch
    logic [2:0]   fld;
    logic [3:0]   wcount;
    logic         ext_p;
    logic         ext_d;
    logic [15:0]  poff;
    logic         hin;
    dspmm_space_t sp;

    // Next-state logic
    always_comb begin
        s_d    = s_q;
        fld    = 3'h0;
        wcount = `DSPMM_WS_ZERO;
        ext_p  = 1'b0;
        ext_d  = 1'b0;
        sp     = DSPMM_SP_PROG;
        poff   = prog_addr;
        hin    = 1'b0;
        s_d.done   = 1'b0;
        // Ready pin synchroniser
        s_d.rdy_s1 = ext_ready;
        s_d.rdy_s2 = s_q.rdy_s1;

        // Register writes land on the request edge;
        // only full-address matches are decoded.
        // Page write keeps the low seven bits.
        // Control write keeps bit 0, rest reads zero.
        //

        // Register writes
        if (mmr_we) begin
            if (mmr_addr == `DSPMM_PAGE_ADDR) begin
                s_d.page = mmr_wdata[6:0]; // RL16
            end
            if (mmr_addr == `DSPMM_WS_ADDR) begin
                s_d.ws = mmr_wdata; // RL21 RL24
            end
            if (mmr_addr == `DSPMM_WSCTL_ADDR) begin
                s_d.dbl = mmr_wdata[0]; // RL25
            end
        end
        if (vec_we) begin
            s_d.vec = vec_wdata; // RL11
        end

        // Far operations load the page from the target;
        // traps and all other operations leave it alone.
        // A trap lands on slot number times four
        // inside the current vector page.
        //

        // Page changes only on far operations and page register writes; table operations set the bus address
        case (pg_op)
            DSPMM_PGOP_FAR:   s_d.page = pg_target[22:16]; // RL17
            DSPMM_PGOP_TABLE: s_d.pbus = pg_target; // RL17
            DSPMM_PGOP_TRAP:  s_d.tpc = {s_q.vec, trap_num, 2'b00}; // RL10 RL11 RL18
            default:          s_d.pbus = s_d.pbus; // RL18
        endcase

        // Register reads, reserved bits zero
        case (mmr_addr)
            `DSPMM_PAGE_ADDR:  s_d.rdata = {9'h000, s_q.page};
            `DSPMM_WS_ADDR:    s_d.rdata = s_q.ws;
            `DSPMM_WSCTL_ADDR: s_d.rdata = {15'h0000, s_q.dbl};
            default:           s_d.rdata = 16'h0000;
        endcase

        // Decode order: overlay, ROM, data mapping,
        // external. The first match wins; the overlay
        // stops below 8000, so it never shadows ROM.
        // Table operations replace the bus address
        // with their own 23-bit target this cycle.
        //

        // Program decode
        s_d.psel = DSPMM_SEL_NONE;
        s_d.pblk = 3'h0;
        if (prog_req) begin
            if (pg_op != DSPMM_PGOP_TABLE) begin
                s_d.pbus = {s_q.page, prog_addr}; // RL13
            end
            poff = s_d.pbus[15:0];
            if (ram_overlay_enable && !poff[`DSPMM_COMMON_BIT]
                && poff >= `DSPMM_DUAL_ACCESS_RAM_LO && !(prog_fetch_ext && rom_protect)) begin
                // Common block on every page
                if (poff <= `DSPMM_DUAL_ACCESS_RAM_HI) begin
                    s_d.psel = DSPMM_SEL_DUAL_ACCESS_RAM; // RL2 RL14
                    s_d.pblk = {1'b0, poff[12:11]}; // RL1
                end else begin
                    s_d.psel = DSPMM_SEL_SINGLE_ACCESS_RAM; // RL4 RL14
                    s_d.pblk = 3'(poff[15:13] - 3'h1); // RL3
                end
            end else if (!boot_memory_strap && s_d.pbus[22:16] == `DSPMM_ZERO_PAGE
                         && poff >= `DSPMM_ROM_LO && !(prog_fetch_ext && rom_protect)) begin
                s_d.psel = DSPMM_SEL_ROM; // RL15 RL6
            end else if (s_d.pbus[22:16] == `DSPMM_PROGRAM_RAM_IN_DATA_ENABLE_PAGE && poff >= `DSPMM_PROGRAM_RAM_IN_DATA_ENABLE_LO
                         && !(prog_fetch_ext && rom_protect)) begin
                s_d.psel = DSPMM_SEL_SINGLE_ACCESS_RAM; // RL5
                s_d.pblk = 3'(poff[15:13] - 3'h1);
            end else begin
                s_d.psel = DSPMM_SEL_EXT; // RL8 RL6
                ext_p    = 1'b1;
            end
        end

        // Data decode has no page: the space is 64K.
        // Addresses below 0080 select nothing here.
        //

        // Data decode
        s_d.dsel = DSPMM_SEL_NONE;
        s_d.dblk = 3'h0;
        if (data_req) begin
            if (data_addr >= `DSPMM_DUAL_ACCESS_RAM_LO && data_addr <= `DSPMM_DUAL_ACCESS_RAM_HI) begin
                s_d.dsel = DSPMM_SEL_DUAL_ACCESS_RAM; // RL2
                s_d.dblk = {1'b0, data_addr[12:11]}; // RL1
            end else if (data_addr >= `DSPMM_SINGLE_ACCESS_RAM_LO && data_addr <= `DSPMM_SINGLE_ACCESS_RAM_HI) begin
                s_d.dsel = DSPMM_SEL_SINGLE_ACCESS_RAM; // RL3
                s_d.dblk = 3'(data_addr[15:13] - 3'h1);
            end else if (program_ram_in_data_enable && data_addr >= `DSPMM_PROGRAM_RAM_IN_DATA_ENABLE_LO) begin
                s_d.dsel = DSPMM_SEL_SINGLE_ACCESS_RAM; // RL5
                s_d.dblk = 3'(data_addr[15:13] - 3'h1);
            end else if (data_addr >= `DSPMM_DUAL_ACCESS_RAM_LO) begin
                s_d.dsel = DSPMM_SEL_EXT; // RL9
                ext_d    = 1'b1;
                sp       = DSPMM_SP_DATA;
            end
        end

        // Host window is compared on all 23 bits.
        //

        // Host port read protection
        hin = host_addr >= `DSPMM_PROT_LO && host_addr <= `DSPMM_PROT_HI;
        s_d.hgnt = host_req && (host_we || !rom_protect || hin); // RL7

        // Wait field choice:
        //   I/O requests win over data and program.
        //   data upper half uses bits 11-9, lower 8-6.
        //   program fields follow the range control:
        //     clear - split on offset bit 15,
        //     set   - split on page zero or not.
        // Count is the field, or twice it when doubled.
        //

        // Wait field selection
        if (io_req) begin
            sp = DSPMM_SP_IO;
        end
        case (sp)
            DSPMM_SP_IO:   fld = s_q.ws[`DSPMM_IO_HI:`DSPMM_IO_LO]; // RL24
            DSPMM_SP_DATA: fld = data_addr[15] ? s_q.ws[`DSPMM_DHI_HI:`DSPMM_DHI_LO]
                                               : s_q.ws[`DSPMM_DLO_HI:`DSPMM_DLO_LO];
            DSPMM_SP_PROG: fld = (s_q.ws[`DSPMM_XPA_BIT] ? (s_d.pbus[22:16] != `DSPMM_ZERO_PAGE)
                                                        : poff[15])
                                 ? s_q.ws[`DSPMM_PHI_HI:`DSPMM_PHI_LO]
                                 : s_q.ws[`DSPMM_PLO_HI:`DSPMM_PLO_LO]; // RL24
            default:       fld = 3'h0;
        endcase
        wcount = s_q.dbl ? {fld, 1'b0} : {1'b0, fld}; // RL22 RL19

        // Gate drops when every wait field is zero;
        // the range control bit does not count.
        //

        // Clock gate for the wait counter
        s_d.gate = s_q.ws[14:0] != 15'h0000; // RL20

        // Sequencer states:
        //   idle  - waits for an external request.
        //   wait  - counts programmed wait states down.
        //   ready - holds until synchronised ready is high.
        // A zero count skips the wait state entirely.
        // The counter is only loaded while the gate is on,
        // so an all-zero register never starts it.
        // Ready low stretches an access past fourteen.
        //

        // External access sequencer
        case (s_q.st)
            DSPMM_IDLE: begin
                if (ext_p || ext_d || io_req) begin
                    s_d.busy = 1'b1;
                    if (s_q.gate && wcount != `DSPMM_WS_ZERO) begin
                        s_d.cnt = wcount;
                        s_d.st  = DSPMM_WAIT;
                    end else begin
                        s_d.st = DSPMM_RDY;
                    end
                end
            end
            DSPMM_WAIT: begin
                if (s_q.cnt == `DSPMM_WS_ONE) begin
                    s_d.st = DSPMM_RDY; // RL19
                end
                s_d.cnt = 4'(s_q.cnt - 4'h1);
            end
            DSPMM_RDY: begin
                if (s_q.rdy_s2) begin
                    s_d.busy = 1'b0; // RL26
                    s_d.done = 1'b1;
                    s_d.st   = DSPMM_IDLE;
                end
            end
            default: s_d.st = DSPMM_IDLE;
        endcase

        if (rst) begin
            s_d       = '0;
            s_d.page  = `DSPMM_PAGE_RST; // RL16
            s_d.ws    = `DSPMM_WS_RST; // RL23
            s_d.dbl   = `DSPMM_WSCTL_RST; // RL23
            s_d.vec   = `DSPMM_VEC_RST; // RL12
            s_d.gate  = 1'b1;
            s_d.st    = DSPMM_IDLE;
            s_d.psel  = DSPMM_SEL_NONE;
            s_d.dsel  = DSPMM_SEL_NONE;
        end
    end

    // All state moves on every clock edge;
    // reset is applied through the next value.
    //

    // State register
    always_ff @(posedge mclk) begin
        s_q <= s_d;
    end

    // Each output is a field of the state flops,
    // so no output sees combinational decode.
    //

    // Outputs straight from flops
    assign mmr_rdata           = s_q.rdata;
    assign program_page_select = s_q.page;
    assign vector_page_pointer = s_q.vec;
    assign trap_pc             = s_q.tpc;
    assign prog_bus_addr       = s_q.pbus;
    assign prog_sel            = s_q.psel;
    assign prog_block          = s_q.pblk;
    assign data_sel            = s_q.dsel;
    assign data_block          = s_q.dblk;
    assign host_grant          = s_q.hgnt;
    assign ext_busy            = s_q.busy;
    assign ext_done            = s_q.done;
    assign wait_clk_gate       = s_q.gate;
endmodule

// ---- tb/dspmm_ext_mem.sv ----
// External memory model that answers promptly or slowly on ready
`timescale 1ns/1ns
module dspmm_ext_mem (
    input  wire logic       mclk,
    input  wire logic       ext_busy,
    input  wire logic [3:0] slow,
    output logic            ext_ready
);
    logic [3:0] cnt;
    // Ready pulled up when idle, held low for slow cycles per access
    always @(posedge mclk) begin
        if (ext_busy !== 1'b1) begin
            cnt <= slow;
            ext_ready <= 1'b1;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            ext_ready <= 1'b0;
        end else begin
            ext_ready <= 1'b1;
        end
    end
endmodule

// ---- tb/dspmm_properties.sv ----
// Port assertions for the memory map and wait-state block
`timescale 1ns/1ns
module dspmm_properties
    import dspmm_pkg::*;
(
    input wire logic                   mclk,
    input wire logic                   rst,
    input wire logic                   mmr_we,
    input wire dspmm_pkg::dspmm_pgop_t pg_op,
    input wire logic [22:0]            pg_target,
    input wire logic [4:0]             trap_num,
    input wire logic                   data_req,
    input wire logic [15:0]            data_addr,
    input wire logic                   program_ram_in_data_enable,
    input wire logic                   rom_protect,
    input wire logic                   host_req,
    input wire logic                   host_we,
    input wire logic [22:0]            host_addr,
    input wire logic [6:0]             program_page_select,
    input wire logic [8:0]             vector_page_pointer,
    input wire logic [15:0]            trap_pc,
    input wire dspmm_pkg::dspmm_sel_t  data_sel,
    input wire logic                   host_grant,
    input wire logic                   ext_busy,
    input wire logic                   ext_done
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Paging and vectors
    property p_far;
        pg_op == DSPMM_PGOP_FAR |=> program_page_select == $past(pg_target[22:16]);
    endproperty
    a_far: assert property (p_far) else $error("far op page wrong");
    property p_keep;
        pg_op inside {DSPMM_PGOP_TABLE, DSPMM_PGOP_TRAP, DSPMM_PGOP_OTHER} && !mmr_we
            |=> $stable(program_page_select);
    endproperty
    a_keep: assert property (p_keep) else $error("page changed");
    property p_trap;
        pg_op == DSPMM_PGOP_TRAP |=> trap_pc == {$past(vector_page_pointer), $past(trap_num), 2'b00};
    endproperty
    a_trap: assert property (p_trap) else $error("trap address wrong");
    // Host protection
    property p_hblk;
        host_req && !host_we && rom_protect && (host_addr < 23'h001000 || host_addr > 23'h001FFF)
            |=> !host_grant;
    endproperty
    a_hblk: assert property (p_hblk) else $error("protected read granted");
    property p_hwr;
        host_req && host_we |=> host_grant;
    endproperty
    a_hwr: assert property (p_hwr) else $error("host write refused");
    // External accesses
    property p_dext;
        data_req && !ext_busy && data_addr[15] && !program_ram_in_data_enable
            |=> data_sel == DSPMM_SEL_EXT;
    endproperty
    a_dext: assert property (p_dext) else $error("data not external");
    property p_done;
        ext_done |-> !ext_busy ##1 !ext_done;
    endproperty
    a_done: assert property (p_done) else $error("done not a pulse");
    property p_bound;
        $rose(ext_busy) |-> ##[1:60] ext_done;
    endproperty
    a_bound: assert property (p_bound) else $error("access never ends");
    c_far: cover property (pg_op == DSPMM_PGOP_FAR);
    c_ref: cover property (host_req && !host_we && rom_protect ##1 !host_grant);
    c_done: cover property (ext_done);
endmodule
bind dspmm_top dspmm_properties i_props (.*);

// ---- tb/tb_top.sv ----
// Self-checking bench for the memory map and wait-state block
`timescale 1ns/1ns
module tb_top;
    import dspmm_pkg::*;
    typedef struct {int k; logic [22:0] v;} dspmm_note_t;
    logic        mclk, rst, boot_memory_strap, rom_protect, ram_overlay_enable, mmr_we;
    logic        program_ram_in_data_enable, vec_we, prog_req, prog_fetch_ext, data_req;
    logic        io_req, host_req, host_we, ext_ready, host_grant, ext_busy, ext_done;
    logic        wait_clk_gate;
    logic [15:0] mmr_addr, mmr_wdata, prog_addr, data_addr, mmr_rdata, trap_pc;
    logic [8:0]  vec_wdata, vector_page_pointer;
    logic [22:0] pg_target, host_addr, prog_bus_addr, got;
    logic [6:0]  program_page_select, pg;
    logic [4:0]  trap_num;
    logic [3:0]  slow;
    logic [2:0]  prog_block, data_block;
    logic [31:0] seed, r;
    dspmm_pgop_t pg_op;
    dspmm_sel_t  prog_sel, data_sel;
    int          failures, compares, cyc, t0;
    dspmm_note_t q[$];
    dspmm_top i_dut (.*);
    dspmm_ext_mem i_mem (.*);
    // Clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [22:0] seen(int k);
        case (k)
            0: return 23'(mmr_rdata);
            1: return 23'(program_page_select);
            2: return 23'(vector_page_pointer);
            3: return 23'(trap_pc);
            4: return 23'(prog_sel);
            5: return 23'(data_sel);
            6: return 23'(host_grant);
            7: return 23'(wait_clk_gate);
            default: return prog_bus_addr;
        endcase
    endfunction
    task automatic print_verdict();
        if (failures == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic note(int k, logic [22:0] v);
        q.push_back('{k, v});
    endtask
    // One edge, then drop every strobe except io_req
    task automatic go();
        @(negedge mclk);
        {mmr_we, vec_we, prog_req, data_req, host_req} = 5'h00;
        pg_op = DSPMM_PGOP_NONE;
    endtask
    task automatic wr(logic [15:0] a, logic [15:0] d);
        mmr_we = 1'b1;
        mmr_addr = a;
        mmr_wdata = d;
        go();
    endtask
    task automatic rd(logic [15:0] a, logic [15:0] e);
        mmr_addr = a;
        note(0, 23'(e));
        go();
    endtask
    task automatic pd(logic [6:0] p, logic ov, logic [15:0] a, dspmm_sel_t e);
        wr(16'h001E, 16'(p));
        ram_overlay_enable = ov;
        prog_req = 1'b1;
        prog_addr = a;
        note(4, 23'(e));
        if (e == DSPMM_SEL_EXT) note(9, {p, a});
        go();
    endtask
    task automatic dd(logic dr, logic [15:0] a, dspmm_sel_t e);
        program_ram_in_data_enable = dr;
        data_req = 1'b1;
        data_addr = a;
        note(5, 23'(e));
        go();
    endtask
    task automatic hs(logic w, logic [22:0] a, logic e);
        host_req = 1'b1;
        host_we = w;
        host_addr = a;
        note(6, 23'(e));
        go();
    endtask
    // Compare oldest notes after each edge; latency note waits for done
    always @(posedge mclk) begin
        #1;
        cyc++;
        if (cyc > 3000) begin
            failures++;
            print_verdict();
        end
        while (q.size() != 0 && (q[0].k != 10 || ext_done === 1'b1)) begin
            compares++;
            got = (q[0].k == 10) ? 23'(cyc - t0) : seen(q[0].k);
            if (q[0].k == 10 ? (got < q[0].v || got > q[0].v + 23'hC) : got !== q[0].v) begin
                failures++;
                $display("[ERR] output %0d exp %h got %h", q[0].k, q[0].v, got);
            end
            void'(q.pop_front());
        end
    end
    // Main sequence
    initial begin
        seed = 32'd29745;
        {boot_memory_strap, rom_protect, ram_overlay_enable, mmr_we, vec_we} = 5'h00;
        {program_ram_in_data_enable, prog_req, prog_fetch_ext, data_req} = 4'h0;
        {io_req, host_req, host_we, mmr_addr, mmr_wdata, prog_addr, data_addr} = 'h0;
        {vec_wdata, pg_target, host_addr, trap_num, slow} = 'h0;
        pg_op = DSPMM_PGOP_NONE;
        rst = 1'b1;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        note(2, 23'h1FF);
        rd(16'h001E, 16'h0000);
        rd(16'h0028, 16'h7FFF);
        rd(16'h002B, 16'h0000);
        rd(16'h0030, 16'h0000);
        r = rnd();
        wr(16'h0028, r[15:0]);
        rd(16'h0028, r[15:0]);
        wr(16'h002B, 16'h0001);
        rd(16'h002B, 16'h0001);
        vec_we = 1'b1;
        vec_wdata = r[24:16];
        go();
        pg = 7'h00;
        for (int i = 1; i < 5; i++) begin
            r = rnd();
            pg_op = dspmm_pgop_t'(i);
            pg_target = r[22:0];
            trap_num = r[27:23];
            if (i == 1) pg = r[22:16];
            note(1, 23'(pg));
            if (i == 3) note(3, 23'({vec_wdata, r[27:23], 2'b00}));
            go();
        end
        pd(7'h05, 1'b1, 16'h0100, DSPMM_SEL_DUAL_ACCESS_RAM);
        pd(7'h05, 1'b1, 16'h3000, DSPMM_SEL_SINGLE_ACCESS_RAM);
        pd(7'h05, 1'b0, 16'h0100, DSPMM_SEL_EXT);
        pd(7'h00, 1'b0, 16'hC000, DSPMM_SEL_ROM);
        pd(7'h02, 1'b0, 16'hC000, DSPMM_SEL_EXT);
        boot_memory_strap = 1'b1;
        pd(7'h00, 1'b0, 16'hC000, DSPMM_SEL_EXT);
        rom_protect = 1'b1;
        prog_fetch_ext = 1'b1;
        pd(7'h00, 1'b1, 16'h0100, DSPMM_SEL_EXT);
        prog_fetch_ext = 1'b0;
        dd(1'b0, 16'h0080, DSPMM_SEL_DUAL_ACCESS_RAM);
        dd(1'b0, 16'h1FFF, DSPMM_SEL_DUAL_ACCESS_RAM);
        dd(1'b0, 16'h7FFF, DSPMM_SEL_SINGLE_ACCESS_RAM);
        dd(1'b1, 16'h8000, DSPMM_SEL_SINGLE_ACCESS_RAM);
        hs(1'b0, 23'h000500, 1'b0);
        hs(1'b0, 23'h001000, 1'b1);
        hs(1'b0, 23'h002000, 1'b0);
        hs(1'b1, 23'h000500, 1'b1);
        rom_protect = 1'b0;
        hs(1'b0, 23'h000500, 1'b1);
        while (ext_busy === 1'b1) go();
        for (int m = 0; m < 4; m++) begin
            r = rnd();
            wr(16'h002B, 16'(m[0]));
            wr(16'h0028, {4'h0, r[2:0], 9'h000});
            slow = {2'b00, r[4:3]};
            t0 = cyc;
            dd(1'b0, {1'b1, r[30:16]}, DSPMM_SEL_EXT);
            note(10, 23'(r[2:0]) << m[0]);
            for (int i = 0; i < 60 && ext_done !== 1'b1; i++) @(negedge mclk);
            go();
        end
        wr(16'h0028, 16'h2000);
        t0 = cyc;
        io_req = 1'b1;
        note(10, 23'h4);
        @(negedge mclk);
        io_req = 1'b0;
        for (int i = 0; i < 60 && ext_done !== 1'b1; i++) @(negedge mclk);
        go();
        wr(16'h0028, 16'h0000);
        go();
        note(7, 23'h0);
        go();
        wr(16'h0028, 16'h7FFF);
        go();
        note(7, 23'h1);
        repeat (3) go();
        print_verdict();
    end
endmodule
